// [src/drc_row_config_regs.svh]
// Offsets, field positions and codes of the row configuration bank
`ifndef DRC_ROW_CONFIG_REGS_SVH
`define DRC_ROW_CONFIG_REGS_SVH

// Register indices; byte address is four times the index
`define DRC_IDX_ROW2_HIGH 10'h065
`define DRC_IDX_ROW3_LOW  10'h066
`define DRC_IDX_ROW3_HIGH 10'h067
`define DRC_IDX_ROW4_LOW  10'h068
`define DRC_IDX_ROW4_HIGH 10'h069
`define DRC_IDX_ROW5_LOW  10'h06a
`define DRC_IDX_ROW5_HIGH 10'h06b
`define DRC_IDX_ROW6_LOW  10'h06c
`define DRC_IDX_ROW6_HIGH 10'h06d

`define DRC_NUM_REGS      9
`define DRC_NUM_ROWS      4
`define DRC_CFG_RESET     8'h00
`define DRC_ADDR_W        12

// Fields of the second configuration byte
`define DRC_MAP_MSB       7
`define DRC_MAP_LSB       6
`define DRC_KIND_MSB      5
`define DRC_KIND_LSB      4
`define DRC_TOP_MSB       3
`define DRC_TOP_LSB       0

// Row technology codes
`define DRC_KIND_FPM      2'b00
`define DRC_KIND_EDO      2'b01
`define DRC_KIND_RSDRAM   2'b10
`define DRC_KIND_SDRAM    2'b11
`define DRC_MAP_OFF       2'b00
`define DRC_SCHEME_OFF    3'h0

// Bus answers
`define DRC_RESP_OKAY     2'b00
`define DRC_RESP_SLVERR   2'b10

`endif

// [src/drc_pkg.sv]
// Types shared by the row configuration bank
package drc_pkg;
  `include "drc_row_config_regs.svh"

  typedef logic [7:0]  drc_byte_t;
  typedef logic [11:0] drc_top_t;

  typedef struct packed {
    drc_byte_t [`DRC_NUM_REGS-1:0] cfg;
    logic                          aw_held;
    logic [`DRC_ADDR_W-1:0]        aw_addr;
    logic                          w_held;
    drc_byte_t                     w_data;
    logic                          w_lane0;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    drc_byte_t                     rdata;
    logic [1:0]                    rresp;
    logic                          hit_valid;
    logic [`DRC_NUM_ROWS-1:0]      hit_row;
    logic [2:0]                    hit_scheme;
    logic [1:0]                    hit_kind;
  } drc_state_s;
endpackage

// [src/drc_row_select.sv]
// Picks the lowest enabled row whose top boundary covers an address
`timescale 1ns/1ps
`include "drc_row_config_regs.svh"
module drc_row_select
  import drc_pkg::*;
(
  // Row configuration
  input  wire drc_top_t [`DRC_NUM_ROWS-1:0] top,
  input  wire logic [`DRC_NUM_ROWS-1:0][1:0] kind,
  input  wire logic [`DRC_NUM_ROWS-1:0][1:0] map,
  // Access
  input  wire drc_top_t                     addr_hi,
  // Result
  output logic [`DRC_NUM_ROWS-1:0]          hit,
  output logic [2:0]                        scheme,
  output logic [1:0]                        hit_kind
);

  // 0 off, 1..3 async tables, 4..7 sync tables
  function automatic logic [2:0] row_scheme(input logic [1:0] k,
                                            input logic [1:0] m);
    if (k[1])
      return {1'b1, m};
    else if (m == `DRC_MAP_OFF)
      return `DRC_SCHEME_OFF;
    else
      return {1'b0, m};
  endfunction

  always_comb begin
    hit      = '0;
    scheme   = `DRC_SCHEME_OFF;
    hit_kind = `DRC_KIND_FPM;
    for (int i = `DRC_NUM_ROWS - 1; i >= 0; i--) begin
      // Not-less-than test, lowest row wins
      if (row_scheme(kind[i], map[i]) != `DRC_SCHEME_OFF &&
          top[i] >= addr_hi) begin
        hit      = '0;
        hit[i]   = 1'b1;
        scheme   = row_scheme(kind[i], map[i]);
        hit_kind = kind[i];
      end
    end
  end

endmodule // drc_row_select

// [src/drc_row_config_regs.sv]
// Row configuration registers with AXI4-Lite access and row decode
`timescale 1ns/1ps
`include "drc_row_config_regs.svh"
module drc_row_config_regs
  import drc_pkg::*;
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Write address
  input  wire logic [`DRC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // Write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // Write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // Read address
  input  wire logic [`DRC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // Read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Row lookup request, address bits 31:20
  input  wire logic                   lookup_valid,
  input  wire drc_top_t               lookup_addr,
  // Row lookup answer
  output logic                        row_valid,
  output logic [`DRC_NUM_ROWS-1:0]    row_select,
  output logic                        row_miss,
  output logic [2:0]                  row_scheme,
  output logic [1:0]                  row_kind
);

  drc_state_s st;
  drc_state_s next_st;

  drc_top_t [`DRC_NUM_ROWS-1:0]       top;
  logic [`DRC_NUM_ROWS-1:0][1:0]      kind;
  logic [`DRC_NUM_ROWS-1:0][1:0]      map;
  logic [`DRC_NUM_ROWS-1:0]           sel_hit;
  logic [2:0]                         sel_scheme;
  logic [1:0]                         sel_kind;
  logic                               aw_fire;
  logic                               w_fire;
  logic                               ar_fire;
  logic                               have_aw;
  logic                               have_w;
  logic [`DRC_ADDR_W-1:0]             wr_addr;
  drc_byte_t                          wr_data;
  logic                               wr_lane0;
  logic [4:0]                         wr_dec;
  logic [4:0]                         rd_dec;

  // Returns {mapped, index into cfg}
  function automatic logic [4:0] reg_index(
      input logic [`DRC_ADDR_W-1:0] a);
    logic [9:0] word;
    word = a[`DRC_ADDR_W-1:2];
    if (word >= `DRC_IDX_ROW2_HIGH && word <= `DRC_IDX_ROW6_HIGH)
      return {1'b1, 4'(word - `DRC_IDX_ROW2_HIGH)};
    else
      return 5'h00;
  endfunction

  // Row n (3..6) uses cfg[2n-5] low byte and cfg[2n-4] high byte
  always_comb begin
    for (int i = 0; i < `DRC_NUM_ROWS; i++) begin
      top[i]  = {st.cfg[2*i+2][`DRC_TOP_MSB:`DRC_TOP_LSB],
                 st.cfg[2*i+1]};
      kind[i] = st.cfg[2*i+2][`DRC_KIND_MSB:`DRC_KIND_LSB];
      map[i]  = st.cfg[2*i+2][`DRC_MAP_MSB:`DRC_MAP_LSB];
    end
  end

  drc_row_select u_select (
    .top      (top),
    .kind     (kind),
    .map      (map),
    .addr_hi  (lookup_addr),
    .hit      (sel_hit),
    .scheme   (sel_scheme),
    .hit_kind (sel_kind)
  );

  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready  = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign have_aw       = st.aw_held || aw_fire;
  assign have_w        = st.w_held || w_fire;
  assign wr_addr       = st.aw_held ? st.aw_addr : s_axi_awaddr;
  assign wr_data       = st.w_held ? st.w_data : s_axi_wdata[7:0];
  assign wr_lane0      = st.w_held ? st.w_lane0 : s_axi_wstrb[0];
  assign wr_dec        = reg_index(wr_addr);
  assign rd_dec        = reg_index(s_axi_araddr);

  always_comb begin
    next_st = st;
    // Write side: address and data in either order
    if (have_aw && have_w) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_dec[4] ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
      if (wr_dec[4] && wr_lane0)
        next_st.cfg[wr_dec[3:0]] = wr_data;
    end else begin
      if (aw_fire) begin
        next_st.aw_held = 1'b1;
        next_st.aw_addr = s_axi_awaddr;
      end
      if (w_fire) begin
        next_st.w_held  = 1'b1;
        next_st.w_data  = s_axi_wdata[7:0];
        next_st.w_lane0 = s_axi_wstrb[0];
      end
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // Read side
    if (ar_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_dec[4] ? st.cfg[rd_dec[3:0]] : `DRC_CFG_RESET;
      next_st.rresp  = rd_dec[4] ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Row decode answer one cycle after the request
    next_st.hit_valid = lookup_valid;
    if (lookup_valid) begin
      next_st.hit_row    = sel_hit;
      next_st.hit_scheme = sel_scheme;
      next_st.hit_kind   = sel_kind;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp  = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp  = st.rresp;
  assign s_axi_rdata  = {24'h00_0000, st.rdata};
  assign row_valid    = st.hit_valid;
  assign row_select   = st.hit_row;
  assign row_miss     = st.hit_valid && (st.hit_row == '0);
  assign row_scheme   = st.hit_scheme;
  assign row_kind     = st.hit_kind;

  kind_report_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lookup_valid && sel_hit[0] |=> row_kind == $past(kind[0]))
    else $error("row kind does not match selected row byte");

  async_disable_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lookup_valid && !kind[0][1] && map[0] == `DRC_MAP_OFF
    |=> !row_select[0])
    else $error("disabled async row was selected");

  async_scheme_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lookup_valid && sel_hit[0] && !kind[0][1]
    |=> row_scheme == {1'b0, $past(map[0])} && row_scheme != 3'h0)
    else $error("async row scheme wrong");

  sync_always_on_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lookup_valid && kind[0][1] && top[0] >= lookup_addr
    |=> row_select == 4'h1 && row_scheme == {1'b1, $past(map[0])})
    else $error("sync row not selected with its scheme");

  low_byte_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lookup_valid && lookup_addr[11:8] == st.cfg[2][3:0] &&
    lookup_addr[7:0] > st.cfg[1] |=> !row_select[0])
    else $error("row 3 taken above its low boundary byte");

  high_bits_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lookup_valid && lookup_addr[11:8] > st.cfg[2][3:0]
    |=> !row_select[0])
    else $error("row 3 taken above its high boundary bits");

  one_row_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    row_valid |-> $onehot0(row_select) &&
    (row_miss == (row_select == 4'h0)))
    else $error("row select not one-hot or miss flag wrong");

  write_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    have_aw && have_w |=> s_axi_bvalid && !s_axi_awready &&
    !s_axi_wready)
    else $error("write response missing after address and data");

  read_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_fire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing one cycle after address");

endmodule // drc_row_config_regs

// [testbench/drc_access_src.sv]
// Access source that issues row lookups toward the bank
`timescale 1ns/1ps
module drc_access_src
  import drc_pkg::*;
(
  // Clock
  input  wire logic aclk,
  // Lookup request
  output logic      lookup_valid,
  output drc_top_t  lookup_addr
);
  initial begin
    lookup_valid = 1'b0;
    lookup_addr  = 12'h000;
  end

  // One-cycle request; address inverted once released
  task automatic issue(input drc_top_t a);
    @(posedge aclk);
    lookup_valid <= 1'b1;
    lookup_addr  <= a;
    @(posedge aclk);
    lookup_valid <= 1'b0;
    lookup_addr  <= ~a;
  endtask
endmodule // drc_access_src

// [testbench/tb_top.sv]
// Self-checking bench for the row configuration bank
`timescale 1ns/1ps
`include "drc_row_config_regs.svh"
module tb_top
  import drc_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp, rkind;
  wire [31:0]  rdata;
  wire         lv, rv, rmiss;
  wire [11:0]  la;
  wire [3:0]   rsel;
  wire [2:0]   rsch;
  int          error_cnt, cmp_count, cyc;

  drc_row_config_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lookup_valid(lv), .lookup_addr(la),
    .row_valid(rv), .row_select(rsel), .row_miss(rmiss),
    .row_scheme(rsch), .row_kind(rkind));
  drc_access_src src (.aclk(aclk), .lookup_valid(lv), .lookup_addr(la));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0000_00, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (awready !== 1'b1);
        @(posedge aclk);
        awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (wready !== 1'b1);
        @(posedge aclk);
        wvalid <= 1'b0;
      end
    join
    while (bvalid !== 1'b1) @(negedge aclk);
    chk(bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(negedge aclk);
    chk(rdata, {24'h0000_00, d});
    chk(rresp, er);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic lk(input logic [11:0] a, input logic [3:0] sel,
                    input logic [2:0] sch, input logic [1:0] k);
    src.issue(a);
    #1;
    chk(rv, 1'b1);
    chk(rsel, sel);
    chk(rmiss, sel == 4'h0);
    chk(rsch, sch);
    chk(rkind, k);
    @(posedge aclk);
    #1;
    chk(rv, 1'b0);
  endtask

  task automatic t_regs();
    logic [11:0] a;
    for (int i = 0; i < `DRC_NUM_REGS; i++) begin
      a = {`DRC_IDX_ROW2_HIGH + i[9:0], 2'b00};
      axr(a, `DRC_CFG_RESET, `DRC_RESP_OKAY);
      axw(a, 8'hA5 ^ i[7:0], 4'h1, `DRC_RESP_OKAY);
      axr(a, 8'hA5 ^ i[7:0], `DRC_RESP_OKAY);
      axw(a, 8'h3C, 4'h0, `DRC_RESP_OKAY);
      axr(a, 8'hA5 ^ i[7:0], `DRC_RESP_OKAY);
    end
    axw(12'h1B8, 8'h11, 4'h1, `DRC_RESP_SLVERR);
    axr(12'h1B8, 8'h00, `DRC_RESP_SLVERR);
    axr(12'h000, 8'h00, `DRC_RESP_SLVERR);
  endtask

  task automatic t_decode();
    axw(12'h198, 8'h0F, 4'h1, `DRC_RESP_OKAY);
    axw(12'h19C, 8'h50, 4'h1, `DRC_RESP_OKAY);
    axw(12'h1A0, 8'h1F, 4'h1, `DRC_RESP_OKAY);
    axw(12'h1A4, 8'h00, 4'h1, `DRC_RESP_OKAY);
    axw(12'h1A8, 8'h2F, 4'h1, `DRC_RESP_OKAY);
    axw(12'h1AC, 8'h31, 4'h1, `DRC_RESP_OKAY);
    axw(12'h1B0, 8'hFF, 4'h1, `DRC_RESP_OKAY);
    axw(12'h1B4, 8'hE3, 4'h1, `DRC_RESP_OKAY);
    lk(12'h000, 4'h1, 3'h1, 2'b01);
    lk(12'h00F, 4'h1, 3'h1, 2'b01);
    lk(12'h010, 4'h4, 3'h4, 2'b11);
    lk(12'h12F, 4'h4, 3'h4, 2'b11);
    lk(12'h130, 4'h8, 3'h7, 2'b10);
    lk(12'h3FF, 4'h8, 3'h7, 2'b10);
    lk(12'h400, 4'h0, 3'h0, 2'b00);
    axw(12'h1A4, 8'h80, 4'h1, `DRC_RESP_OKAY);
    lk(12'h010, 4'h2, 3'h2, 2'b00);
    axw(12'h1A4, 8'hD0, 4'h1, `DRC_RESP_OKAY);
    lk(12'h01F, 4'h2, 3'h3, 2'b01);
    axw(12'h19C, 8'h30, 4'h1, `DRC_RESP_OKAY);
    lk(12'h000, 4'h1, 3'h4, 2'b11);
    axw(12'h19C, 8'h60, 4'h1, `DRC_RESP_OKAY);
    lk(12'h00F, 4'h1, 3'h5, 2'b10);
    axw(12'h19C, 8'hB0, 4'h1, `DRC_RESP_OKAY);
    lk(12'h010, 4'h2, 3'h3, 2'b01);
    lk(12'h000, 4'h1, 3'h6, 2'b11);
  endtask

  task automatic t_rereset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(12'h1B4, `DRC_CFG_RESET, `DRC_RESP_OKAY);
    lk(12'h000, 4'h0, 3'h0, 2'b00);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata  = 32'h0000_0000;
    wstrb  = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_decode();
    t_rereset();
    stop_test();
  end
endmodule // tb_top
